// ===== comm_unit_status_word.sv
// Status word generator, error handling, fault lamp and syntax address word.
// Assumes all inputs synchronous to clk; only the unit status word is written
// into the controller's word memory, through the write strobe and data outputs.
`timescale 1ns/1ps
`include "status_word_regs.svh"

module comm_unit_status_word
   import status_word_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        run_digit,
   input  wire logic [7:0]  component_count,
   input  wire logic        unit_done,
   input  wire logic [4:0]  unit_done_num,
   input  wire logic        unit_type_none,
   input  wire logic        watchdog_err,
   input  wire logic        syntax_err,
   input  wire logic [15:0] syntax_err_addr,
   input  wire logic        alloc_err,
   input  wire logic        report_fail,
   output logic [15:0]      unit_status_word,
   output logic [15:0]      syntax_addr_word,
   output logic             status_wr,
   output logic [15:0]      status_wr_addr,
   output logic             comms_enable,
   output logic             fault_lamp
);

   // =====================================================================
   // Helpers
   function automatic logic [7:0] to_bcd(input logic [4:0] bin);
      logic [3:0] tens;
      logic [4:0] rem5;
      tens = (bin >= 5'd30) ? 4'd3 : (bin >= 5'd20) ? 4'd2 : (bin >= 5'd10) ? 4'd1 : 4'd0;
      rem5 = bin - 5'({1'b0, tens} * 5'd10);
      to_bcd = {tens, rem5[3:0]};
   endfunction : to_bcd

   // =====================================================================
   // State and next values
   op_state_e   state;
   op_state_e   next_state;
   logic [7:0]  err_code;
   logic [7:0]  next_err_code;
   logic [7:0]  last_unit;
   logic        syntax_held;
   logic        cant_report;
   logic [23:0] blink_cnt;
   logic        blink_phase;

   wire fatal_now    = watchdog_err | alloc_err;
   wire any_error    = (state == ST_SOFT) | (state == ST_FATAL);
   wire is_fatal     = (state == ST_FATAL);
   wire zero_unit    = (component_count == 8'h00) | ~run_digit | unit_type_none;
   wire running      = (state == ST_RUN) & ~cant_report;
   wire new_fatal    = fatal_now & ~is_fatal;
   wire lamp_steady  = is_fatal | cant_report;

   // =====================================================================
   // Next state; fatal beats syntax, fatal latches until reset
   always_comb
   begin
      next_state    = state;
      next_err_code = err_code;
      unique case (state)
         ST_IDLE, ST_RUN:
         begin
            if (watchdog_err)
            begin
               next_state    = ST_FATAL;
               next_err_code = `CODE_WATCHDOG;
            end
            else if (alloc_err)
            begin
               next_state    = ST_FATAL;
               next_err_code = `CODE_ALLOC;
            end
            else if (syntax_err)
            begin
               next_state    = ST_SOFT;
               next_err_code = `CODE_SYNTAX;
            end
            else
               next_state = run_digit ? ST_RUN : ST_IDLE;
         end
         ST_SOFT:
         begin
            if (watchdog_err | alloc_err)
            begin
               next_state    = ST_FATAL;
               next_err_code = watchdog_err ? `CODE_WATCHDOG : `CODE_ALLOC;
            end
            else if (~run_digit)
            begin
               next_state    = ST_IDLE;
               next_err_code = 8'h00;
            end
         end
         ST_FATAL:
            next_state = ST_FATAL;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state    <= ST_IDLE;
         err_code <= 8'h00;
      end
      else if (clk_en)
      begin
         state    <= next_state;
         err_code <= next_err_code;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         last_unit <= `UNIT_NONE;
      else if (clk_en)
      begin
         if (zero_unit)
            last_unit <= `UNIT_NONE;
         else if (unit_done & (state == ST_RUN))
            last_unit <= to_bcd(unit_done_num);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syntax_held      <= 1'b0;
         syntax_addr_word <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (syntax_err & ~syntax_held & ~is_fatal)
         begin
            syntax_held      <= 1'b1;
            syntax_addr_word <= syntax_err_addr;
         end
         else if ((state == ST_SOFT) & ~run_digit & ~syntax_err)
            syntax_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cant_report <= 1'b0;
      else if (clk_en & report_fail)
         cant_report <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blink_cnt   <= 24'h000000;
         blink_phase <= 1'b0;
      end
      else if (clk_en)
      begin
         if (blink_cnt == 24'(`BLINK_CYCLES - 1))
         begin
            blink_cnt   <= 24'h000000;
            blink_phase <= ~blink_phase;
         end
         else
            blink_cnt <= blink_cnt + 24'h000001;
      end
   end

   // =====================================================================
   // Status word and outputs
   wire [15:0] err_word = {(is_fatal ? `TOP_DIGIT_FATAL : `TOP_DIGIT_OK),
                           `DIGIT_STOP, err_code};
   wire [15:0] ok_word  = {`TOP_DIGIT_OK, (running ? `DIGIT_RUN : `DIGIT_STOP),
                           (zero_unit ? `UNIT_NONE : last_unit)};
   wire [15:0] next_word = any_error ? err_word : ok_word;
   wire        word_changed = (next_word != unit_status_word);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unit_status_word <= `STATUS_RESET;
         status_wr        <= 1'b0;
         fault_lamp       <= 1'b0;
      end
      else if (clk_en)
      begin
         unit_status_word <= next_word;
         status_wr        <= word_changed & ~cant_report;
         fault_lamp       <= lamp_steady | ((state == ST_SOFT) & blink_phase);
      end
   end

   assign status_wr_addr = `UNIT_STATUS_WORD_OFFSET;
   // Halt drops at once on a new fatal error, before the error word is registered
   assign comms_enable   = running & (unit_status_word[15] == 1'b0) & ~new_fatal;

   // =====================================================================
   // Checks
   err_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && $rose(state == ST_FATAL) |=> unit_status_word[15])
      else $error("error bit not set after fatal error");
   err_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && (state == ST_IDLE || state == ST_RUN) && watchdog_err
      ##1 clk_en |=> unit_status_word[7:0] == 8'h01)
      else $error("watchdog code missing");
   alloc_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state == ST_RUN && !watchdog_err && alloc_err
      ##1 clk_en |=> unit_status_word == 16'h8015 && fault_lamp)
      else $error("allocation error word wrong");
   stop_digit_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && any_error |=> unit_status_word[11:8] == 4'h0)
      else $error("stop digit not zero during error");
   no_fatal_top_a: assert property (@(posedge clk) disable iff (!rst_n)
      state != ST_FATAL && $past(state) != ST_FATAL |-> unit_status_word[15:12] == 4'h0)
      else $error("top digit set without fatal error");
   fatal_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_fatal |=> is_fatal && !comms_enable)
      else $error("left fatal state");
   report_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && report_fail ##1 clk_en |=> !comms_enable && !status_wr && fault_lamp)
      else $error("report failure not handled");
   syntax_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      syntax_held && clk_en && state == ST_SOFT |=> $stable(syntax_addr_word))
      else $error("syntax address overwritten");
   unit_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !any_error && zero_unit |=> unit_status_word[7:0] == 8'h00)
      else $error("unit byte not zero");

   fatal_c:  cover property (@(posedge clk) disable iff (!rst_n) state == ST_FATAL);
   syntax_c: cover property (@(posedge clk) disable iff (!rst_n) state == ST_SOFT && fault_lamp);
   unit_c:   cover property (@(posedge clk) disable iff (!rst_n) unit_status_word[7:0] == 8'h31);

endmodule : comm_unit_status_word

// ===== comm_unit_status_word_test.sv
// Self-checking bench for the status word block.
// Assumes the design, package and controller model compile first.
`timescale 1ns/1ps
module comm_unit_status_word_test;
   import status_word_pkg::*;
   typedef struct {logic r; logic [7:0] c; logic [4:0] n; logic z; logic [15:0] m, e;} row_s;
   logic        clk, rst_n, clk_en, run_digit, unit_done, unit_type_none;
   logic        watchdog_err, syntax_err, alloc_err, report_fail;
   logic        status_wr, comms_enable, fault_lamp;
   logic [7:0]  component_count;
   logic [4:0]  unit_done_num;
   logic [15:0] syntax_err_addr, unit_status_word, syntax_addr_word, status_wr_addr;
   logic [15:0] mem_status;
   int          err_total, checks_done, wr_count, k;
   row_s        rows[6] = '{'{1, 8'h05, 12, 0, 16'hFFFF, 16'h0112},
                            '{1, 8'h05, 31, 0, 16'hFFFF, 16'h0131},
                            '{1, 8'h05, 0, 0, 16'hFFFF, 16'h0100},
                            '{1, 8'h00, 7, 0, 16'hF0FF, 16'h0000},
                            '{1, 8'h05, 9, 1, 16'hF0FF, 16'h0000},
                            '{0, 8'h05, 5, 0, 16'hFFFF, 16'h0000}};

   comm_unit_status_word i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .run_digit(run_digit), .component_count(component_count), .unit_done(unit_done),
      .unit_done_num(unit_done_num), .unit_type_none(unit_type_none),
      .watchdog_err(watchdog_err), .syntax_err(syntax_err),
      .syntax_err_addr(syntax_err_addr), .alloc_err(alloc_err), .report_fail(report_fail),
      .unit_status_word(unit_status_word), .syntax_addr_word(syntax_addr_word),
      .status_wr(status_wr), .status_wr_addr(status_wr_addr),
      .comms_enable(comms_enable), .fault_lamp(fault_lamp));
   cpu_word_model i_cpu (.clk(clk), .rst_n(rst_n), .status_wr(status_wr),
      .status_wr_addr(status_wr_addr), .unit_status_word(unit_status_word),
      .mem_status(mem_status), .wr_count(wr_count));

   initial
   begin
      clk = 0;
      forever #20 clk = ~clk;
   end

   task automatic results;
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : cmp16

   // Bounded wait for the status word, then compare
   task automatic wait_word(input logic [15:0] exp, input logic [15:0] m, input string msg);
      @(negedge clk);
      for (int i = 0; i < 20 && (unit_status_word & m) !== exp; i++)
         @(negedge clk);
      cmp16(unit_status_word & m, exp, msg);
      if ((unit_status_word & m) !== exp)
         results();
      else
         @(posedge clk);
   endtask : wait_word

   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      run_digit <= 1'b0;
      repeat (n) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   task automatic done_pulse(input logic [4:0] n);
      unit_done <= 1'b1;
      unit_done_num <= n;
      @(posedge clk);
      unit_done <= 1'b0;
   endtask : done_pulse

   initial
   begin
      {rst_n, run_digit, unit_done, unit_type_none, watchdog_err} = '0;
      {syntax_err, alloc_err, report_fail, unit_done_num, syntax_err_addr} = '0;
      clk_en = 1'b1;
      component_count = 8'h05;
      err_total = 0;
      checks_done = 0;
      @(negedge clk);
      cmp16(unit_status_word, 16'h0000, "reset word");
      cmp16(status_wr_addr, 16'h0001, "write offset");
      @(posedge clk);
      // Two edges already passed in reset; eight in all
      do_reset(6);
      wait_word(16'h0000, 16'hFFFF, "idle unit 00");
      // ==========================================
      // Table of no-error cases
      for (k = 0; k < 6; k++)
      begin
         run_digit <= rows[k].r;
         component_count <= rows[k].c;
         unit_type_none <= rows[k].z;
         @(posedge clk);
         done_pulse(rows[k].n);
         wait_word(rows[k].e, rows[k].m, "unit row");
      end
      // ==========================================
      // Clock enable low freezes every register
      clk_en <= 1'b0;
      run_digit <= 1'b1;
      done_pulse(5'd4);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp16(unit_status_word, 16'h0000, "frozen word");
      cmp16(comms_enable, 1'b0, "frozen state");
      @(posedge clk);
      clk_en <= 1'b1;
      // ==========================================
      // Syntax error: first address kept
      run_digit <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      cmp16(comms_enable, 1'b1, "running enables");
      @(posedge clk);
      syntax_err <= 1'b1;
      syntax_err_addr <= 16'h1234;
      @(posedge clk);
      syntax_err_addr <= 16'h5678;
      @(posedge clk);
      syntax_err <= 1'b0;
      wait_word(16'h0002, 16'hFFFF, "syntax word");
      cmp16(syntax_addr_word, 16'h1234, "first address");
      cmp16(comms_enable, 1'b0, "syntax halt");
      run_digit <= 1'b0;
      wait_word(16'h0000, 16'hFFFF, "syntax cleared");
      // ==========================================
      // Fatal codes; run is refused afterwards
      for (k = 0; k < 2; k++)
      begin
         do_reset(2);
         run_digit <= 1'b1;
         repeat (3) @(posedge clk);
         if (k == 0)
            watchdog_err <= 1'b1;
         else
            alloc_err <= 1'b1;
         @(posedge clk);
         {watchdog_err, alloc_err} <= 2'b00;
         wait_word(k ? 16'h8015 : 16'h8001, 16'hFFFF, "fatal word");
         repeat (4) @(posedge clk);
         @(negedge clk);
         cmp16(mem_status, k ? 16'h8015 : 16'h8001, "word written");
         cmp16(fault_lamp, 1'b1, "lamp steady");
         cmp16(comms_enable, 1'b0, "fatal halt");
         @(posedge clk);
      end
      // ==========================================
      // Report failure: halt, lamp, no writes
      do_reset(2);
      run_digit <= 1'b1;
      report_fail <= 1'b1;
      @(posedge clk);
      report_fail <= 1'b0;
      done_pulse(5'd3);
      repeat (6) @(posedge clk);
      @(negedge clk);
      cmp16(comms_enable, 1'b0, "report halt");
      cmp16(fault_lamp, 1'b1, "report lamp");
      cmp16(16'(wr_count), 16'h0000, "no writes");
      results();
   end
endmodule : comm_unit_status_word_test

// ===== cpu_word_model.sv
// Controller side model: captures status words written into word memory.
// Assumes the status write strobe is a one-cycle pulse on the clk domain.
`timescale 1ns/1ps
module cpu_word_model
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        status_wr,
   input  wire logic [15:0] status_wr_addr,
   input  wire logic [15:0] unit_status_word,
   output logic [15:0]      mem_status,
   output int               wr_count
);
   // ==========================================
   // Word memory capture
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_status <= 16'h0000;
         wr_count   <= 0;
      end
      else if (status_wr && status_wr_addr == 16'h0001)
      begin
         mem_status <= unit_status_word;
         wr_count   <= wr_count + 1;
      end
   end
endmodule : cpu_word_model

// ===== status_word_pkg.sv
// Types shared by the status word block.
// Assumes the constants header sits in the same folder.
package status_word_pkg;
`include "status_word_regs.svh"

   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'b0001,
      ST_RUN    = 4'b0010,
      ST_SOFT   = 4'b0100,
      ST_FATAL  = 4'b1000
   } op_state_e;

   typedef enum logic [1:0]
   {
      LAMP_OFF   = 2'b00,
      LAMP_STEADY = 2'b01,
      LAMP_BLINK = 2'b10
   } lamp_mode_e;

endpackage : status_word_pkg

// ===== status_word_regs.svh
// Offsets, digit values, codes and timing counts for the status word block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef STATUS_WORD_REGS_SVH
`define STATUS_WORD_REGS_SVH

`define CTRL_WORD_OFFSET        16'h0000
`define UNIT_STATUS_WORD_OFFSET 16'h0001
`define SYNTAX_ADDR_OFFSET      16'h0002

`define CODE_WATCHDOG           8'h01
`define CODE_SYNTAX             8'h02
`define CODE_ALLOC              8'h15
`define TOP_DIGIT_FATAL         4'h8
`define TOP_DIGIT_OK            4'h0
`define DIGIT_RUN               4'h1
`define DIGIT_STOP              4'h0
`define UNIT_NONE               8'h00
`define UNIT_MAX                5'h1F
`define STATUS_RESET            16'h0000

`define BLINK_HALF_MS           250
`define CLK_KHZ                 25000
`define BLINK_CYCLES            (`BLINK_HALF_MS * `CLK_KHZ)

`endif
